/* File: rtl/adpsr_defs.svh */
/*
  register offsets, field positions, reset values and timing counts for the
  control and status register segment. assumes a 40 MHz system clock.
*/
`ifndef ADPSR_DEFS_SVH
`define ADPSR_DEFS_SVH

// register word indices; the byte address on the bus is the index times four
`define ADPSR_IDX_BQ_MARK    8'h5C
`define ADPSR_IDX_DAC        8'h5D
`define ADPSR_IDX_PIN_DIR    8'h60
`define ADPSR_IDX_PIN_FUNC   8'h61
`define ADPSR_IDX_DSP        8'h66
`define ADPSR_IDX_DIE        8'h67
`define ADPSR_IDX_POWER      8'h68
`define ADPSR_IDX_MUTE       8'h69
`define ADPSR_IDX_PHASE      8'h6A
`define ADPSR_IDX_IRQ_STAT   8'h7C
`define ADPSR_IDX_IRQ_MASK   8'h7D
`define ADPSR_IDX_MUTE_TIME  8'h7E

// reset values
`define ADPSR_RST_DAC        8'hF8
`define ADPSR_RST_ZERO       8'h00
`define ADPSR_RST_MUTE_TIME  8'h00

// dac control fields
`define ADPSR_DAC_RATE_BIT   7
`define ADPSR_DAC_MATCH_ON   2'h0
`define ADPSR_DAC_MATCH_OFF  2'h3

// pin function codes
`define ADPSR_FN_LOW         5'h00
`define ADPSR_FN_BOTH_MUTE   5'h03
`define ADPSR_FN_LEFT_MUTE   5'h04
`define ADPSR_FN_RIGHT_MUTE  5'h05
`define ADPSR_FN_CLK_BAD     5'h06
`define ADPSR_FN_RSVD_A      5'h07
`define ADPSR_FN_RSVD_B      5'h09
`define ADPSR_FN_FAULT       5'h0B

// dsp bypass bits
`define ADPSR_DSP_SPLIT_BIT  3
`define ADPSR_DSP_FIR_BIT    2
`define ADPSR_DSP_DRC_BIT    1
`define ADPSR_DSP_EQ_BIT     0

// interrupt status bits
`define ADPSR_IRQ_LMUTE_BIT  0
`define ADPSR_IRQ_RMUTE_BIT  1
`define ADPSR_IRQ_CLK_BIT    2
`define ADPSR_IRQ_FAULT_BIT  3
`define ADPSR_IRQ_RSVD_BIT   4

// auto-mute base time: 11.5 ms in tenths of a millisecond, 96 samples per ms,
// rounded up to whole samples
`define ADPSR_MUTE_BASE_US10 115
`define ADPSR_MUTE_BASE_SMP  ((`ADPSR_MUTE_BASE_US10 * 96 + 9) / 10)

`endif

/* File: rtl/adpsr_pkg.sv */
/*
  types shared by the register segment, its bench and its monitor.
  assumes adpsr_defs.svh is on the include path.
*/
package adpsr_pkg;

  typedef enum logic [1:0] {
    ADPSR_PWR_DEEP  = 2'h0,
    ADPSR_PWR_SLEEP = 2'h1,
    ADPSR_PWR_HIGHZ = 2'h2,
    ADPSR_PWR_PLAY  = 2'h3
  } adpsr_power_t;

  typedef struct packed {
    logic        sample_valid;
    logic        left_zero;
    logic        right_zero;
  } adpsr_audio_t;

  typedef struct packed {
    logic        clk_invalid;
    logic        fault;
    adpsr_power_t power;
  } adpsr_status_t;

  typedef struct packed {
    logic        rate_slow;
    logic [1:0]  dither_enable;
    logic [2:0]  dither_level;
    logic        element_matching;
    logic        biquad_first_coef_marker;
    logic        split_coefs;
    logic        bypass_fir;
    logic        bypass_drc;
    logic        bypass_eq;
  } adpsr_ctrl_t;

  typedef enum logic [1:0] {
    ADPSR_BUS_IDLE  = 2'b00,
    ADPSR_BUS_WRITE = 2'b01,
    ADPSR_BUS_READ  = 2'b11
  } adpsr_bus_state_t;

endpackage

/* File: rtl/adpsr_regs.sv */
/*
  control and status register segment of a digital-input class-d amplifier:
  dac modulator settings, multipurpose address pin, dsp bypass switches,
  identity, power state and auto-mute status, plus an interrupt block.
  assumes an ahb-lite master with single word transfers and synchronous
  status inputs from the surrounding device.
*/
// How it works
// - software sets marker bit before first coefficient
// - dac bit 7 picks modulator rate
// - dither enable bits 6-5 pick stages
// - dither level bits 4-2 pick amplitude
// - dac resets 0xF8; select 00 enables matching
// - pin direction bit 0: input or output
// - function 00000 low, 01011 fault low
// - mute codes: both, left, right
// - 00110 clock invalid; 00111, 01001 reserved
// - bit 3 separates or shares coefficients
// - bit 2 bypasses the fir filter
// - bit 1 bypasses l/r compression
// - bit 0 bypasses l/r equalizer
// - read-only die identity at 67h
// - power state read-only at 68h
// - right mute status at bit 1
// - left mute status at bit 0
// - mute after programmed zero-sample run
`timescale 1ns/1ps
`include "adpsr_defs.svh"
module adpsr_regs
  import adpsr_pkg::*;
#(
  parameter logic [7:0] DIE_IDENTITY = 8'h5A, // arbitrary value
  parameter int         CNT_W        = 20
) (
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     hsel_in,
  input  wire logic [31:0]              haddr_in,
  input  wire logic [1:0]               htrans_in,
  input  wire logic                     hwrite_in,
  input  wire logic [2:0]               hsize_in,
  input  wire logic [31:0]              hwdata_in,
  input  wire logic                     hready_in,
  output logic [31:0]                   hrdata_out,
  output logic                          hreadyout_out,
  output logic                          hresp_out,
  input  wire adpsr_pkg::adpsr_audio_t  audio_in,
  input  wire adpsr_pkg::adpsr_status_t status_in,
  input  wire logic                     adr_pin_in,
  output logic                          adr_pin_out,
  output logic                          adr_pin_oe_out,
  output logic                          adr_pin_sampled_out,
  output adpsr_pkg::adpsr_ctrl_t        ctrl_out,
  output logic                          irq_out
);
  import adpsr_pkg::*;

  typedef struct packed {
    logic        ph_valid;
    logic        ph_write;
    logic [7:0]  ph_index;
    logic [7:0]  bq_mark;
    logic [7:0]  dac;
    logic [7:0]  pin_dir;
    logic [7:0]  pin_func;
    logic [7:0]  dsp;
    logic [7:0]  phase;
    logic [7:0]  mute_time;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [4:0]  ev_prev;
    logic [31:0] rdata;
    logic        pin_q;
    logic        pin_in_q;
  } adpsr_state_t;

  adpsr_state_t st;
  adpsr_state_t next_st;
  logic [1:0]   rst_sync;
  logic         rst_n;
  logic         left_muted;
  logic         right_muted;
  logic [4:0]   events;
  logic [4:0]   ev_rise;
  logic         addr_take;
  logic         pin_level;
  logic [7:0]   mute_byte;

  // power-on release through two flops; only the second is used
  // kept apart from the state struct, which resets on its output
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  adpsr_zero_run #(
    .CNT_W           (CNT_W)
  ) u_left_run (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n),
    .sample_valid_in (audio_in.sample_valid),
    .zero_in         (audio_in.left_zero),
    .time_sel_in     (st.mute_time[6:4]),
    .muted_out       (left_muted)
  );

  adpsr_zero_run #(
    .CNT_W           (CNT_W)
  ) u_right_run (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n),
    .sample_valid_in (audio_in.sample_valid),
    .zero_in         (audio_in.right_zero),
    .time_sel_in     (st.mute_time[2:0]),
    .muted_out       (right_muted)
  );

  // byte address to register index; low two bits are dropped, so misaligned addresses hit the containing word
  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic is_reserved_fn(input logic [4:0] fn);
    is_reserved_fn = (fn == `ADPSR_FN_RSVD_A) || (fn == `ADPSR_FN_RSVD_B);
  endfunction

  // pin function mux; unlisted codes park the pin low
  function automatic logic pin_value(input logic [4:0] fn, input logic lm,
                                     input logic rm, input logic ck,
                                     input logic ft);
    unique case (fn)
      `ADPSR_FN_BOTH_MUTE:  pin_value = lm & rm;
      `ADPSR_FN_LEFT_MUTE:  pin_value = lm;
      `ADPSR_FN_RIGHT_MUTE: pin_value = rm;
      `ADPSR_FN_CLK_BAD:    pin_value = ck;
      `ADPSR_FN_FAULT:      pin_value = ~ft;
      default:              pin_value = 1'b0;
    endcase
  endfunction

  assign mute_byte = {6'h00, right_muted, left_muted};
  assign events    = {is_reserved_fn(st.pin_func[4:0]) & st.pin_dir[0],
                      status_in.fault, status_in.clk_invalid,
                      right_muted, left_muted};
  assign ev_rise   = events & ~st.ev_prev;
  assign addr_take = hsel_in & hready_in & htrans_in[1];
  assign pin_level = pin_value(st.pin_func[4:0], left_muted, right_muted,
                               status_in.clk_invalid, status_in.fault);

  always_comb begin
    next_st          = st;
    next_st.ev_prev  = events;
    next_st.pin_q    = pin_level;
    next_st.pin_in_q = adr_pin_in;
    if (hready_in) begin
      next_st.ph_valid = addr_take;
      next_st.ph_write = hwrite_in;
      next_st.ph_index = word_index(haddr_in);
    end
    // write data phase; read-only words have no branch here
    if (st.ph_valid && st.ph_write) begin
      unique case (st.ph_index)
        `ADPSR_IDX_BQ_MARK:   next_st.bq_mark   = {7'h00, hwdata_in[0]};
        `ADPSR_IDX_DAC:       next_st.dac       = hwdata_in[7:0];
        `ADPSR_IDX_PIN_DIR:   next_st.pin_dir   = {7'h00, hwdata_in[0]};
        `ADPSR_IDX_PIN_FUNC:  next_st.pin_func  = {3'h0, hwdata_in[4:0]};
        `ADPSR_IDX_DSP:       next_st.dsp       = {4'h0, hwdata_in[3:0]};
        `ADPSR_IDX_PHASE:     next_st.phase     = hwdata_in[7:0];
        `ADPSR_IDX_IRQ_MASK:  next_st.irq_mask  = hwdata_in[4:0];
        `ADPSR_IDX_MUTE_TIME: next_st.mute_time = {1'b0, hwdata_in[6:4], 1'b0, hwdata_in[2:0]};
        `ADPSR_IDX_IRQ_STAT:  next_st.irq_stat  = st.irq_stat & ~hwdata_in[4:0];
        default: ;
      endcase
    end
    // set wins over a same-cycle write-one clear
    next_st.irq_stat = next_st.irq_stat | ev_rise;
    // read data registered at the address phase
    next_st.rdata = 32'h0000_0000;
    if (addr_take && !hwrite_in) begin
      unique case (word_index(haddr_in))
        `ADPSR_IDX_BQ_MARK:   next_st.rdata = {24'h0, st.bq_mark};
        `ADPSR_IDX_DAC:       next_st.rdata = {24'h0, st.dac};
        `ADPSR_IDX_PIN_DIR:   next_st.rdata = {24'h0, st.pin_dir};
        `ADPSR_IDX_PIN_FUNC:  next_st.rdata = {24'h0, st.pin_func};
        `ADPSR_IDX_DSP:       next_st.rdata = {24'h0, st.dsp};
        `ADPSR_IDX_DIE:       next_st.rdata = {24'h0, DIE_IDENTITY};
        `ADPSR_IDX_POWER:     next_st.rdata = {30'h0, status_in.power};
        `ADPSR_IDX_MUTE:      next_st.rdata = {24'h0, mute_byte};
        `ADPSR_IDX_PHASE:     next_st.rdata = {24'h0, st.phase};
        `ADPSR_IDX_IRQ_STAT:  next_st.rdata = {27'h0, st.irq_stat};
        `ADPSR_IDX_IRQ_MASK:  next_st.rdata = {27'h0, st.irq_mask};
        `ADPSR_IDX_MUTE_TIME: next_st.rdata = {24'h0, st.mute_time};
        default:              next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st.ph_valid  <= 1'b0;
      st.ph_write  <= 1'b0;
      st.ph_index  <= 8'h00;
      st.bq_mark   <= `ADPSR_RST_ZERO;
      st.dac       <= `ADPSR_RST_DAC;
      st.pin_dir   <= `ADPSR_RST_ZERO;
      st.pin_func  <= `ADPSR_RST_ZERO;
      st.dsp       <= `ADPSR_RST_ZERO;
      st.phase     <= `ADPSR_RST_ZERO;
      st.mute_time <= `ADPSR_RST_MUTE_TIME;
      st.irq_stat  <= 5'h00;
      st.irq_mask  <= 5'h00;
      st.ev_prev   <= 5'h00;
      st.rdata     <= 32'h0000_0000;
      st.pin_q     <= 1'b0;
      st.pin_in_q  <= 1'b0;
    end else begin
      st.ph_valid  <= next_st.ph_valid;
      st.ph_write  <= next_st.ph_write;
      st.ph_index  <= next_st.ph_index;
      st.bq_mark   <= next_st.bq_mark;
      st.dac       <= next_st.dac;
      st.pin_dir   <= next_st.pin_dir;
      st.pin_func  <= next_st.pin_func;
      st.dsp       <= next_st.dsp;
      st.phase     <= next_st.phase;
      st.mute_time <= next_st.mute_time;
      st.irq_stat  <= next_st.irq_stat;
      st.irq_mask  <= next_st.irq_mask;
      st.ev_prev   <= next_st.ev_prev;
      st.rdata     <= next_st.rdata;
      st.pin_q     <= next_st.pin_q;
      st.pin_in_q  <= next_st.pin_in_q;
    end
  end

  // zero-wait slave, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = st.rdata;

  // pin driven only when configured as output
  assign adr_pin_oe_out      = st.pin_dir[0];
  assign adr_pin_out         = st.pin_q;
  assign adr_pin_sampled_out = st.pin_dir[0] ? 1'b0 : st.pin_in_q;

  // rate bit: 1 slow 3.072 MHz, 0 fast 6.144 MHz
  assign ctrl_out.rate_slow                = st.dac[`ADPSR_DAC_RATE_BIT];
  assign ctrl_out.dither_enable            = st.dac[6:5];
  assign ctrl_out.dither_level             = st.dac[4:2];
  // only the 00 code enables matching; mixed codes treated as off
  assign ctrl_out.element_matching         = (st.dac[1:0] == `ADPSR_DAC_MATCH_ON);
  assign ctrl_out.biquad_first_coef_marker = st.bq_mark[0];
  assign ctrl_out.split_coefs              = st.dsp[`ADPSR_DSP_SPLIT_BIT];
  assign ctrl_out.bypass_fir               = st.dsp[`ADPSR_DSP_FIR_BIT];
  assign ctrl_out.bypass_drc               = st.dsp[`ADPSR_DSP_DRC_BIT];
  assign ctrl_out.bypass_eq                = st.dsp[`ADPSR_DSP_EQ_BIT];

  assign irq_out = |(st.irq_stat & st.irq_mask);
endmodule

/* File: rtl/adpsr_zero_run.sv */
/*
  counts consecutive zero samples of one channel and raises the mute level
  once the run reaches the programmed length. assumes sample_valid pulses
  once per sample and the caller handles the sample-rate scaling.
*/
`timescale 1ns/1ps
`include "adpsr_defs.svh"
module adpsr_zero_run #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             sample_valid_in,
  input  wire logic             zero_in,
  input  wire logic [2:0]       time_sel_in,
  output logic                  muted_out
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             muted;
  } adpsr_run_t;

  adpsr_run_t st;
  adpsr_run_t next_st;
  logic [CNT_W-1:0] limit;

  // run lengths in samples at 96 kHz; no scaling for the sample strobe rate
  function automatic logic [CNT_W-1:0] run_len(input logic [2:0] sel);
    unique case (sel)
      3'h0:    run_len = CNT_W'(`ADPSR_MUTE_BASE_SMP);
      3'h1:    run_len = CNT_W'(5088);
      3'h2:    run_len = CNT_W'(10224);
      3'h3:    run_len = CNT_W'(25584);
      3'h4:    run_len = CNT_W'(51360);
      3'h5:    run_len = CNT_W'(102240);
      3'h6:    run_len = CNT_W'(255840);
      default: run_len = CNT_W'(511680);
    endcase
  endfunction

  always_comb begin
    limit   = run_len(time_sel_in);
    next_st = st;
    if (sample_valid_in) begin
      if (!zero_in) begin
        next_st.count = '0;
        next_st.muted = 1'b0;
      end else if (st.count >= limit - CNT_W'(1)) begin
        next_st.muted = 1'b1;
      end else begin
        next_st.count = st.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign muted_out = st.muted;
endmodule

/* File: testbench/adpsr_regs_bench.sv */
/*
  self-checking bench: reset values, field decoding, read-only places,
  address pin, auto-mute and interrupt. assumes rtl and defs on include path.
*/
`timescale 1ns/1ps
`include "adpsr_defs.svh"
module adpsr_regs_bench;
  import adpsr_pkg::*;
  localparam logic [7:0] DIE_VAL = 8'hC3; // arbitrary value
  logic          clk_in = 1'b0;
  logic          resetn_in;
  logic          hsel_in;
  logic [31:0]   haddr_in;
  logic [1:0]    htrans_in;
  logic          hwrite_in;
  logic [31:0]   hwdata_in;
  logic [31:0]   hrdata_out;
  logic          hready;
  logic          hresp_out;
  adpsr_audio_t  audio_in;
  adpsr_status_t status_in;
  logic          pin_ext;
  logic          pin_out;
  logic          pin_oe;
  logic          pin_smp;
  adpsr_ctrl_t   ctrl_out;
  logic          irq_out;
  int            err_count = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  wire           pin_in = pin_oe ? pin_out : pin_ext;

  always #12.5 clk_in = ~clk_in;

  adpsr_regs #(.DIE_IDENTITY(DIE_VAL), .CNT_W(20)) adpsr_regs_i (
    .clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in,
    .hready_in(hready), .hrdata_out, .hreadyout_out(hready), .hresp_out, .audio_in, .status_in,
    .adr_pin_in(pin_in), .adr_pin_out(pin_out), .adr_pin_oe_out(pin_oe),
    .adr_pin_sampled_out(pin_smp), .ctrl_out, .irq_out);

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read data is taken at the edge closing the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    hwrite_in <= w;
    haddr_in <= {22'h0, a, 2'b00};
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    r = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic t_reset();
    chk({20'h0, ctrl_out}, 32'hFA0);
    rd_chk(`ADPSR_IDX_DAC, 32'hF8);
    rd_chk(`ADPSR_IDX_PIN_DIR, 32'h0);
    rd_chk(`ADPSR_IDX_DSP, 32'h0);
  endtask

  task automatic t_dac();
    logic [7:0] v;
    logic [6:0] g;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[1:0], i[2:0], {2{i[1]}}};
      wr(`ADPSR_IDX_DAC, {24'h0, v});
      idle(1);
      g = {ctrl_out.rate_slow, ctrl_out.dither_enable, ctrl_out.dither_level, ctrl_out.element_matching};
      chk({25'h0, g}, {25'h0, v[7:2], v[1:0] == 2'b00});
      rd_chk(`ADPSR_IDX_DAC, {24'h0, v});
    end
  endtask

  task automatic t_dsp();
    logic [4:0] g;
    for (int i = 0; i < 16; i++) begin
      wr(`ADPSR_IDX_DSP, 32'(i));
      wr(`ADPSR_IDX_BQ_MARK, {31'h0, i[0]});
      idle(1);
      g = {ctrl_out.split_coefs, ctrl_out.bypass_fir, ctrl_out.bypass_drc, ctrl_out.bypass_eq, ctrl_out.biquad_first_coef_marker};
      chk({27'h0, g}, {27'h0, i[3:0], i[0]});
      rd_chk(`ADPSR_IDX_DSP, 32'(i));
    end
  endtask

  // read-only places keep their contents under writes; unmapped reads zero
  task automatic t_ro();
    wr(`ADPSR_IDX_DIE, 32'hFF);
    wr(`ADPSR_IDX_MUTE, 32'hFF);
    wr(8'h40, 32'hFF);
    wr(`ADPSR_IDX_MUTE_TIME, 32'hFF);
    rd_chk(`ADPSR_IDX_MUTE_TIME, 32'h77);
    wr(`ADPSR_IDX_MUTE_TIME, 32'h0);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_in);
      status_in.power <= adpsr_power_t'(p[1:0]);
      wr(`ADPSR_IDX_POWER, 32'hFF);
      idle(3);
      rd_chk(`ADPSR_IDX_POWER, 32'(p));
    end
    rd_chk(`ADPSR_IDX_DIE, {24'h0, DIE_VAL});
    rd_chk(`ADPSR_IDX_MUTE, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask

  task automatic pin_case(input logic [4:0] f, input logic ft, input logic ck, input logic e);
    @(posedge clk_in);
    status_in.fault <= ft;
    status_in.clk_invalid <= ck;
    wr(`ADPSR_IDX_PIN_FUNC, {27'h0, f});
    idle(3);
    chk({31'h0, pin_out}, {31'h0, e});
  endtask

  task automatic t_pin();
    @(posedge clk_in);
    pin_ext <= 1'b1;
    idle(3);
    chk({30'h0, pin_oe, pin_smp}, 32'h1);
    wr(`ADPSR_IDX_PIN_DIR, 32'h1);
    idle(3);
    chk({30'h0, pin_oe, pin_smp}, 32'h2);
    pin_case(`ADPSR_FN_LOW, 1'b1, 1'b1, 1'b0);
    pin_case(`ADPSR_FN_FAULT, 1'b1, 1'b0, 1'b0);
    pin_case(`ADPSR_FN_FAULT, 1'b0, 1'b0, 1'b1);
    pin_case(`ADPSR_FN_CLK_BAD, 1'b0, 1'b1, 1'b1);
    pin_case(`ADPSR_FN_CLK_BAD, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic samples(input int n);
    repeat (n) begin
      @(posedge clk_in);
      audio_in.sample_valid <= 1'b1;
      @(posedge clk_in);
      audio_in.sample_valid <= 1'b0;
    end
  endtask

  // base run is 1104 samples: quiet at 1100, muted by 1110
  task automatic t_mute();
    rd_chk(`ADPSR_IDX_IRQ_STAT, 32'hC);
    wr(`ADPSR_IDX_IRQ_STAT, 32'h1F);
    wr(`ADPSR_IDX_IRQ_MASK, 32'h1);
    @(posedge clk_in);
    audio_in.left_zero <= 1'b1;
    samples(1100);
    idle(2);
    rd_chk(`ADPSR_IDX_MUTE, 32'h0);
    samples(10);
    idle(3);
    rd_chk(`ADPSR_IDX_MUTE, 32'h1);
    chk({31'h0, irq_out}, 32'h1);
    pin_case(`ADPSR_FN_LEFT_MUTE, 1'b0, 1'b0, 1'b1);
    pin_case(`ADPSR_FN_RIGHT_MUTE, 1'b0, 1'b0, 1'b0);
    pin_case(`ADPSR_FN_BOTH_MUTE, 1'b0, 1'b0, 1'b0);
    wr(`ADPSR_IDX_IRQ_STAT, 32'h1);
    idle(2);
    chk({31'h0, irq_out}, 32'h0);
    @(posedge clk_in);
    audio_in.right_zero <= 1'b1;
    samples(1110);
    idle(3);
    rd_chk(`ADPSR_IDX_MUTE, 32'h3);
    rd_chk(`ADPSR_IDX_IRQ_STAT, 32'h2);
    chk({31'h0, irq_out}, 32'h0);
    pin_case(`ADPSR_FN_BOTH_MUTE, 1'b0, 1'b0, 1'b1);
    pin_case(`ADPSR_FN_RIGHT_MUTE, 1'b0, 1'b0, 1'b1);
    wr(`ADPSR_IDX_IRQ_MASK, 32'h3);
    idle(2);
    chk({31'h0, irq_out}, 32'h1);
  endtask

  // run is about 4800 cycles; the ceiling leaves ample margin
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    resetn_in = 1'b0;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hwdata_in = 32'h0;
    audio_in = '0;
    status_in = '0;
    pin_ext = 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    idle(1);
    t_reset();
    t_dac();
    t_dsp();
    t_ro();
    t_pin();
    t_mute();
    give_verdict();
  end
endmodule

/* File: testbench/adpsr_regs_monitor.sv */
/*
  port checks for the register segment, bound into adpsr_regs.
  assumes single word ahb-lite transfers with hready fed from hreadyout.
*/
`timescale 1ns/1ps
`include "adpsr_defs.svh"
module adpsr_regs_monitor
  import adpsr_pkg::*;
#(
  parameter logic [7:0] DIE_IDENTITY = 8'h5A // arbitrary value
) (
  input wire logic                     clk_in,
  input wire logic                     resetn_in,
  input wire logic                     hsel_in,
  input wire logic [31:0]              haddr_in,
  input wire logic [1:0]               htrans_in,
  input wire logic                     hwrite_in,
  input wire logic [31:0]              hwdata_in,
  input wire logic                     hready_in,
  input wire logic [31:0]              hrdata_out,
  input wire logic                     hreadyout_out,
  input wire logic                     hresp_out,
  input wire adpsr_pkg::adpsr_status_t status_in,
  input wire logic                     adr_pin_out,
  input wire logic                     adr_pin_oe_out,
  input wire adpsr_pkg::adpsr_ctrl_t   ctrl_out
);
  logic        pend;
  logic        pw;
  logic [7:0]  pidx;
  logic        dn;
  logic [7:0]  didx;
  logic [31:0] dd;
  logic [4:0]  fn;

  // mirrors both bus phases; dn marks the cycle after a write landed
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend <= 1'b0;
      pw   <= 1'b0;
      pidx <= 8'h00;
      dn   <= 1'b0;
      didx <= 8'h00;
      dd   <= 32'h0;
      fn   <= 5'h00;
    end else if (hready_in) begin
      pend <= hsel_in & htrans_in[1];
      pw   <= hwrite_in;
      pidx <= haddr_in[9:2];
      dn   <= pend & pw;
      didx <= pidx;
      dd   <= hwdata_in;
      if (pend && pw && pidx == `ADPSR_IDX_PIN_FUNC) begin
        fn <= hwdata_in[4:0];
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or error response");
  AST_DAC_FIELDS: assert property (dn && didx == `ADPSR_IDX_DAC |->
    {ctrl_out.rate_slow, ctrl_out.dither_enable, ctrl_out.dither_level} == dd[7:2])
    else $error("dac fields differ from write");
  AST_DAC_MATCH: assert property (dn && didx == `ADPSR_IDX_DAC |->
    ctrl_out.element_matching == (dd[1:0] == 2'b00)) else $error("element matching wrong");
  AST_DSP_BITS: assert property (dn && didx == `ADPSR_IDX_DSP |->
    {ctrl_out.split_coefs, ctrl_out.bypass_fir, ctrl_out.bypass_drc, ctrl_out.bypass_eq} == dd[3:0])
    else $error("bypass bits differ from write");
  AST_MARKER: assert property (dn && didx == `ADPSR_IDX_BQ_MARK |->
    ctrl_out.biquad_first_coef_marker == dd[0]) else $error("marker differs from write");
  AST_OE_DIR: assert property (dn && didx == `ADPSR_IDX_PIN_DIR |->
    adr_pin_oe_out == dd[0]) else $error("pin direction wrong");
  AST_PIN_FAULT: assert property ($past(fn) == `ADPSR_FN_FAULT && $past(adr_pin_oe_out) |->
    adr_pin_out == !$past(status_in.fault)) else $error("fault pin wrong");
  AST_PIN_CLK: assert property ($past(fn) == `ADPSR_FN_CLK_BAD && $past(adr_pin_oe_out) |->
    adr_pin_out == $past(status_in.clk_invalid)) else $error("clock pin wrong");
  AST_DIE_READ: assert property (pend && !pw && pidx == `ADPSR_IDX_DIE |->
    hrdata_out == {24'h0, DIE_IDENTITY}) else $error("die identity wrong");

  cover property (dn && didx == `ADPSR_IDX_DAC);
  cover property ($past(fn) == `ADPSR_FN_FAULT && !adr_pin_out);
  cover property (pend && !pw && pidx == `ADPSR_IDX_DIE);
endmodule

bind adpsr_regs adpsr_regs_monitor #(.DIE_IDENTITY(DIE_IDENTITY)) adpsr_regs_monitor_i (
  .clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
  .hrdata_out, .hreadyout_out, .hresp_out, .status_in, .adr_pin_out, .adr_pin_oe_out, .ctrl_out
);
